/* File: verilog/lcd_clock_source_and_bias_control.sv */
// Purpose: decodes oscillator-control, bias and frame-frequency commands; drives the clock pin
// Assumes: cmd_valid marks a whole command byte; osc_tick is one pulse per internal oscillator
//          period, clk_io_pin_i already synchronous
// Notes:   frame_tick is one pulse per lcd frame
//
// Overview of operation
// - bits 7..3 equal 00011 mean oscillator control; low three bits load config.
// - bit 2 gives external rate, 0 is 9.6 kHz, 1 is 230 kHz.
// - bit 1 gates clock out; 0 leaves the pin high impedance.
// - bit 0 selects source; 1 uses external clock, pin becomes input.
// - internal source ignores rate bit; external source ignores output gate.
// - after power-on the pin stays high impedance until enabled.
// - clock driven only with internal source and output gate set.
// - pin carries the prescaled intermediate clock, not raw oscillator.
// - power-down: gate off gives high impedance, gate on drives high.
// - while reset is asserted the pin is high impedance.
// - internal source with gate on outputs intermediate clock, 9.6 kHz at q 24.
// - external 9.6 kHz clock is divided by a fixed 48 for frames.
// - internal or 230 kHz external divide by 48 times q.
// - internal oscillator nominal 230 kHz; all timing from selected source.
// - bits 7..2 equal 000001 mean bias; 00/01 quarter, 11 third, 10 half.
// - frame command loads five-bit code; default 01110 gives q 24.
// - power-down bit stops the internal oscillator.
`timescale 1ns/1ps
module lcd_clock_source_and_bias_control (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // command byte from the serial interface
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_byte,
  // power mode from mode settings
  input  wire logic                      power_down_bit,
  // timing sources
  input  wire logic                      osc_tick,
  input  wire logic                      clk_io_pin_i,
  // clock pin drive
  output logic                           clk_io_pin_o,
  output logic                           clk_io_pin_oe,
  // status and timing
  output lcd_clk_pkg::osc_cfg_type       osc_cfg_q,
  output lcd_clk_pkg::bias_type          bias_q,
  output logic [4:0]                     frame_prescale_code,
  output logic                           osc_enable,
  output logic                           frame_tick
);
  lcd_clk_pkg::osc_cfg_type   osc_cfg_d;
  lcd_clk_pkg::bias_type      bias_d;
  lcd_clk_pkg::pin_drive_type pin_q;
  lcd_clk_pkg::pin_drive_type pin_d;
  logic [4:0]                 code_q;
  logic [4:0]                 code_d;
  logic                       osc_en_q;
  logic                       osc_en_d;
  logic                       ext_prev_q;
  logic                       src_tick;
  logic                       slow_tick;
  logic                       inter_level;
  logic                       inter_wrap;
  logic                       frame_wrap;
  logic [7:0]                 q_factor;

  // divide factor q for each prescaler code
  function automatic logic [7:0] q_of(input logic [4:0] code);
    logic [7:0] q;
    case (code)
      5'h00: q = 8'h50;
      5'h01: q = 8'h44;
      5'h02: q = 8'h3c;
      5'h03: q = 8'h35;
      5'h04: q = 8'h30;
      5'h05: q = 8'h2c;
      5'h06: q = 8'h28;
      5'h07: q = 8'h25;
      5'h08: q = 8'h22;
      5'h09: q = 8'h20;
      5'h0a: q = 8'h1e;
      5'h0b: q = 8'h1c;
      5'h0c: q = 8'h1b;
      5'h0d: q = 8'h19;
      5'h0e: q = 8'h18;
      5'h0f: q = 8'h17;
      5'h10: q = 8'h16;
      5'h11: q = 8'h15;
      5'h12: q = 8'h14;
      5'h13: q = 8'h13;
      5'h14: q = 8'h12;
      5'h15: q = 8'h11;
      default: q = 8'h10;
    endcase
    return q;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  always_comb begin
    osc_cfg_d = osc_cfg_q;
    bias_d    = bias_q;
    code_d    = code_q;
    if (cmd_valid) begin
      if (cmd_byte[7:3] == lcd_clk_pkg::osc_ctrl_prefix) begin
        osc_cfg_d.ext_rate_select = cmd_byte[lcd_clk_pkg::rate_sel_bit];
        osc_cfg_d.clk_out_gate    = cmd_byte[lcd_clk_pkg::gate_bit];
        osc_cfg_d.ext_source      = cmd_byte[lcd_clk_pkg::osc_bit];
      end
      if (cmd_byte[7:2] == lcd_clk_pkg::bias_prefix) begin
        case (cmd_byte[1:0])
          2'b11:   bias_d = lcd_clk_pkg::bias_third;
          2'b10:   bias_d = lcd_clk_pkg::bias_half;
          default: bias_d = lcd_clk_pkg::bias_quarter;
        endcase
      end
      // frame code load, unused codes dropped
      if (cmd_byte[7:5] == lcd_clk_pkg::frame_prefix && cmd_byte[4:0] <= lcd_clk_pkg::prescale_last) begin
        code_d = cmd_byte[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_cfg_q <= '0;
      bias_q    <= lcd_clk_pkg::bias_quarter;
      code_q    <= lcd_clk_pkg::prescale_default;
    end else begin
      osc_cfg_q <= osc_cfg_d;
      bias_q    <= bias_d;
      code_q    <= code_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source select and division
  // oscillator runs only when used and powered up
  assign src_tick  = osc_cfg_q.ext_source ? (clk_io_pin_i & ~ext_prev_q) : (osc_tick & osc_en_q);
  // rate bit only counts with the external source
  assign slow_tick = osc_cfg_q.ext_source & ~osc_cfg_q.ext_rate_select;
  assign q_factor  = q_of(code_q);

  // intermediate clock is source divided by q
  lcd_clk_divider #(.width(8)) prescale_div (
    .clk     (clk),
    .rst     (rst),
    .tick    (src_tick & ~slow_tick),
    .divide  (q_factor),
    .level_q (inter_level),
    .wrap_q  (inter_wrap)
  );

  // frame is 48 intermediate periods or 48 slow input periods
  lcd_clk_divider #(.width(8)) frame_div (
    .clk     (clk),
    .rst     (rst),
    .tick    (slow_tick ? src_tick : inter_wrap),
    .divide  (lcd_clk_pkg::base_divide),
    .level_q (),
    .wrap_q  (frame_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_comb begin
    osc_en_d = ~power_down_bit & ~osc_cfg_q.ext_source;
    pin_d    = '0;
    if (osc_cfg_q.ext_source) begin
      // external source: pin is input, gate ignored
      pin_d = '0;
    end else if (power_down_bit) begin
      // static high when gated, else released
      pin_d.clk_io_pin_oe = osc_cfg_q.clk_out_gate;
      pin_d.clk_io_pin_o  = osc_cfg_q.clk_out_gate;
    end else begin
      // drive intermediate clock only when gated on
      pin_d.clk_io_pin_oe = osc_cfg_q.clk_out_gate;
      pin_d.clk_io_pin_o  = osc_cfg_q.clk_out_gate & inter_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q      <= '0;
      osc_en_q   <= 1'b0;
      ext_prev_q <= 1'b0;
      frame_tick <= 1'b0;
    end else begin
      pin_q      <= pin_d;
      osc_en_q   <= osc_en_d;
      ext_prev_q <= clk_io_pin_i;
      frame_tick <= frame_wrap;
    end
  end

  assign clk_io_pin_o        = pin_q.clk_io_pin_o;
  assign clk_io_pin_oe       = pin_q.clk_io_pin_oe;
  assign frame_prescale_code = code_q;
  assign osc_enable          = osc_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  osc_cmd_load_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_byte[7:3] == lcd_clk_pkg::osc_ctrl_prefix |=> osc_cfg_q == $past(cmd_byte[2:0]))
    else $error("oscillator control not loaded");
  osc_other_keep_a: assert property (@(posedge clk) disable iff (rst)
    !cmd_valid |=> $stable(osc_cfg_q) && $stable(bias_q))
    else $error("settings changed without command");
  ext_no_drive_a: assert property (@(posedge clk) disable iff (rst)
    osc_cfg_q.ext_source |=> !clk_io_pin_oe)
    else $error("pin driven with external source");
  gate_off_float_a: assert property (@(posedge clk) disable iff (rst)
    !osc_cfg_q.clk_out_gate |=> !clk_io_pin_oe)
    else $error("pin driven with gate off");
  down_pin_high_a: assert property (@(posedge clk) disable iff (rst)
    power_down_bit && osc_cfg_q.clk_out_gate && !osc_cfg_q.ext_source |=> clk_io_pin_oe && clk_io_pin_o)
    else $error("power-down pin not high");
  down_osc_stop_a: assert property (@(posedge clk) disable iff (rst)
    power_down_bit |=> !osc_enable)
    else $error("oscillator runs in power-down");
  reset_release_a: assert property (@(posedge clk)
    rst |=> !clk_io_pin_oe && osc_cfg_q == '0 && code_q == lcd_clk_pkg::prescale_default)
    else $error("reset state wrong");
  bias_third_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_byte == {lcd_clk_pkg::bias_prefix, 2'b11} |=> bias_q == lcd_clk_pkg::bias_third)
    else $error("third bias not set");
  frame_from_inter_a: assert property (@(posedge clk) disable iff (rst)
    frame_wrap && !$past(slow_tick) |-> $past(inter_wrap))
    else $error("frame end without intermediate wrap");
endmodule

/* File: verilog/lcd_clk_pkg.sv */
// Purpose: shared constants and types for the lcd clock source and bias control
// Assumes: 125 MHz system clock, command bytes delivered already decoded from the bus
// Notes:   oscillator and external clock are modelled as synchronous tick inputs
package lcd_clk_pkg;
  localparam logic [4:0] osc_ctrl_prefix   = 5'h03;
  localparam logic [5:0] bias_prefix       = 6'h01;
  localparam logic [2:0] frame_prefix      = 3'h1;
  localparam int         rate_sel_bit      = 2;
  localparam int         gate_bit          = 1;
  localparam int         osc_bit           = 0;
  localparam logic [4:0] prescale_default  = 5'h0e;
  localparam logic [4:0] prescale_last     = 5'h16;
  localparam logic [7:0] base_divide       = 8'h30;
  localparam int         osc_nominal_hz    = 230000;
  localparam int         ext_slow_hz       = 9600;
  localparam int         ext_fast_hz       = 230000;

  typedef enum logic [1:0] {
    bias_quarter,
    bias_third,
    bias_half
  } bias_type;

  typedef struct packed {
    logic ext_rate_select;
    logic clk_out_gate;
    logic ext_source;
  } osc_cfg_type;

  typedef struct packed {
    logic clk_io_pin_o;
    logic clk_io_pin_oe;
  } pin_drive_type;
endpackage

/* File: verilog/lcd_clk_divider.sv */
// Purpose: divides a tick stream by a programmable count, giving a clock level and an end pulse
// Assumes: tick is a one-cycle pulse, synchronous to clk
// Notes:   the output level is high for the first half count, so duty is one half for even counts
`timescale 1ns/1ps
module lcd_clk_divider #(
  parameter int width = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // count control
  input  wire logic             tick,
  input  wire logic [width-1:0] divide,
  // results
  output logic                  level_q,
  output logic                  wrap_q
);
  logic [width-1:0] count_q;
  logic [width-1:0] count_d;
  logic             level_d;
  logic             wrap_d;

  always_comb begin
    count_d = count_q;
    wrap_d  = 1'b0;
    level_d = level_q;
    if (tick) begin
      if (count_q >= divide - width'(1)) begin
        count_d = '0;
        wrap_d  = 1'b1;
      end else begin
        count_d = count_q + width'(1);
      end
      level_d = (count_d < (divide >> 1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      level_q <= 1'b0;
      wrap_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      level_q <= level_d;
      wrap_q  <= wrap_d;
    end
  end
endmodule

/* File: dv/host_cmd_model.sv */
// Purpose: host side, sends command bytes and supplies the external clock
// Assumes: one command byte at most every other cycle
// Notes:   a stopped external clock sits low, as a driven host output would
`timescale 1ns/1ps
module host_cmd_model (
  // clock
  input  wire logic       clk,
  // external clock request
  input  wire logic       ext_run,
  // command bus and clock pin level
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  output logic            ext_level
);
  logic [2:0] ph_q = 3'h0;
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    ext_level = 1'b0;
  end
  always @(posedge clk) begin
    ph_q <= ph_q + 3'h1;
    if (!ext_run) ext_level <= 1'b0;
    else if (ph_q == 3'h7) ext_level <= ~ext_level;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte  <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte  <= ~b;
  endtask
endmodule

/* File: dv/tb_lcd_clock_source_and_bias_control.sv */
// Purpose: self-checking bench for the clock source and bias control
// Assumes: osc_tick every 8 cycles, external clock period 16 cycles
// Notes:   frame and clock periods are counted in source ticks between pulses
`timescale 1ns/1ps
`define chk(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_lcd_clock_source_and_bias_control;
  logic clk = 1'b0, rst = 1'b1, pwr_down = 1'b0, osc_tick = 1'b0, ext_run = 1'b0;
  logic cmd_valid, pin_o, pin_oe, osc_en, frame_tick, ext_level, pin_d = 1'b0, po_d = 1'b0;
  logic [7:0] cmd_byte, b;
  logic [4:0] code, e_code;
  lcd_clk_pkg::osc_cfg_type cfg, e_cfg;
  lcd_clk_pkg::bias_type    bias, e_bias;
  int error_cnt = 0, checks = 0, seed = 32'h89cc, cyc = 0;
  int ticks = 0, edges = 0, per_tick = 0, per_edge = 0, otick = 0, o_per = 0, ftick_n = 0;
  logic [7:0] b_list [9] = '{8'h37, 8'h3f, 8'h36, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1f, 8'h50};
  // the wire level: device drive wins, else the host's clock
  wire pin_lvl = pin_oe ? pin_o : ext_level;
  wire rise = pin_lvl && !pin_d;
  always #4 clk = ~clk;
  host_cmd_model u_host (.clk(clk), .ext_run(ext_run), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
                         .ext_level(ext_level));
  lcd_clock_source_and_bias_control DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .power_down_bit(pwr_down), .osc_tick(osc_tick), .clk_io_pin_i(pin_lvl), .clk_io_pin_o(pin_o),
    .clk_io_pin_oe(pin_oe), .osc_cfg_q(cfg), .bias_q(bias), .frame_prescale_code(code),
    .osc_enable(osc_en), .frame_tick(frame_tick));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 8 == 0);
    pin_d <= pin_lvl;
    po_d <= pin_o;
    if (pin_o && !po_d) begin
      o_per <= otick;
      otick <= int'(osc_tick);
    end else otick <= otick + int'(osc_tick);
    if (frame_tick) begin
      per_tick <= ticks;
      per_edge <= edges;
      ticks <= int'(osc_tick);
      edges <= int'(rise);
      ftick_n <= ftick_n + 1;
    end else begin
      ticks <= ticks + int'(osc_tick);
      edges <= edges + int'(rise);
    end
  end
  function automatic void model(input logic [7:0] c);
    if (c[7:3] == 5'h03) e_cfg = lcd_clk_pkg::osc_cfg_type'(c[2:0]);
    if (c[7:2] == 6'h01) e_bias = (c[1:0] == 2'h3) ? lcd_clk_pkg::bias_third :
                                  (c[1:0] == 2'h2) ? lcd_clk_pkg::bias_half : lcd_clk_pkg::bias_quarter;
    if (c[7:5] == 3'h1 && c[4:0] <= 5'h16) e_code = c[4:0];
  endfunction
  task automatic defaults;
    e_cfg = lcd_clk_pkg::osc_cfg_type'(3'h0);
    e_bias = lcd_clk_pkg::bias_quarter;
    e_code = 5'h0e;
  endtask
  task automatic cmd(input logic [7:0] c);
    u_host.send(c);
    model(c);
    @(posedge clk);
    @(negedge clk);
    `chk(cfg, e_cfg)
    `chk(bias, e_bias)
    `chk(code, e_code)
  endtask
  task automatic frames(input int n);
    int s;
    s = ftick_n;
    for (int i = 0; i < 60000 && ftick_n < s + n; i++) @(posedge clk);
    @(negedge clk);
    `chk(ftick_n >= s + n, 1'b1)
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    defaults();
    `chk(pin_oe, 1'b0)
    `chk(cfg, e_cfg)
    `chk(code, e_code)
    // corner bytes: unused code, last code, every bias field, then random mix
    foreach (b_list[i]) cmd(b_list[i]);
    for (int i = 0; i < 150; i++) begin
      b = 8'($random(seed));
      case (b[7:6])
        2'h0: b = {5'h03, b[2:0]};
        2'h1: b = {6'h01, b[1:0]};
        2'h2: b = {3'h1, b[4:0]};
        default: b = b;
      endcase
      cmd(b);
    end
    // internal source, gate on, rate bit set but ignored, q of 16
    cmd(8'h36);
    cmd(8'h1e);
    `chk(pin_oe, 1'b1)
    frames(3);
    `chk(per_tick, 768)
    `chk(o_per, 16)
    `chk(osc_en, 1'b1)
    @(posedge clk);
    pwr_down <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `chk({pin_oe, pin_o}, 2'h3)
    `chk(osc_en, 1'b0)
    cmd(8'h18);
    `chk(pin_oe, 1'b0)
    @(posedge clk);
    pwr_down <= 1'b0;
    cmd(8'h1a);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `chk(pin_oe, 1'b0)
    @(posedge clk);
    rst <= 1'b0;
    defaults();
    ext_run <= 1'b1;
    // external slow clock with gate set: pin stays an input
    cmd(8'h1b);
    @(negedge clk);
    `chk(pin_oe, 1'b0)
    frames(3);
    `chk(per_edge, 48)
    cmd(8'h36);
    cmd(8'h1d);
    frames(3);
    `chk(per_edge, 768)
    close_out();
  end
endmodule
